// ===== mem_model.sv
module mem_model (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Read port from the block
  input wire logic mem_req,
  input wire logic [15:0] mem_addr,
  output logic mem_ack,
  output logic [15:0] mem_rdata,
  // Wait cycles before each answer
  input wire logic [3:0] delay
);
  // Word store, filled by the bench
  logic [15:0] words [0:4095];
  // Cycles waited on the open request
  logic [3:0] wait_r;
  // Answer now
  logic go;

  // Answer once the wait has run out, never twice per request
  assign go = mem_req && !mem_ack && wait_r >= delay;

  // Data only valid with ack; otherwise it toggles so stale use shows
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      mem_ack <= 1'b0;
      mem_rdata <= 16'hA5A5;
      wait_r <= 4'h0;
    end else begin
      mem_ack <= go;
      mem_rdata <= go ? words[mem_addr[12:1]] : ~mem_rdata;
      wait_r <= (mem_req && !go && !mem_ack) ? wait_r + 4'h1 : 4'h0;
    end
  end
endmodule

// ===== oag_pkg.sv
package oag_pkg;
  // Word and byte pointer steps
  localparam logic [15:0] WORD_STEP = 16'h0002;
  localparam logic [15:0] BYTE_STEP = 16'h0001;
  // Special register numbers
  localparam logic [2:0] SP_IDX = 3'h6;
  localparam logic [2:0] PC_IDX = 3'h7;
  // Register values after reset
  localparam logic [15:0] REG_RESET = 16'h0000;
  localparam logic [15:0] WORD_RESET = 16'h0000;
  // Field positions within the instruction word
  localparam int BYTE_BIT = 15;
  localparam int SRC_LO = 6;
  localparam int DST_LO = 0;
  localparam int REG_LO = 6;
  // Addressing mode codes
  localparam logic [2:0] MODE_REG = 3'h0;
  localparam logic [2:0] MODE_DEF = 3'h1;
  localparam logic [2:0] MODE_INC = 3'h2;
  localparam logic [2:0] MODE_INCDEF = 3'h3;
  localparam logic [2:0] MODE_DECR = 3'h4;
  localparam logic [2:0] MODE_DECDEF = 3'h5;
  localparam logic [2:0] MODE_IDX = 3'h6;
  localparam logic [2:0] MODE_IDXDEF = 3'h7;

  // Instruction layout classes
  typedef enum logic [1:0] {FMT_NONE, FMT_SINGLE, FMT_DOUBLE, FMT_REGSRC} fmt_t;
  // Operation classes recognised by the decoder
  typedef enum logic [4:0] {
    other_op, dual_op, clear_op, invert_op, plus_one_op, minus_one_op,
    sign_flip_op, carry_add_op, carry_subtract_op, probe_op,
    rotate_right_op, rotate_left_op, arith_shift_right_op,
    arith_shift_left_op, jump_op, byte_swap_op, status_byte_read_op,
    status_byte_write_op, sign_extend_op, test_and_set_op,
    locked_write_op, xor_op, arith_shift_op, arith_shift_pair_op,
    product_op, quotient_op
  } op_kind_t;
  // Which operand is being resolved
  typedef enum logic {SEL_SRC, SEL_DST} sel_t;
  // Sequencer states
  typedef enum logic [2:0] {
    ST_IDLE, ST_FETCH, ST_DECODE, ST_SPEC, ST_XWORD, ST_INDIR, ST_DONE
  } state_t;

  // Decoded instruction
  typedef struct packed {
    fmt_t fmt;
    op_kind_t kind;
    logic byte_op;
  } decode_t;
  // Resolved operand
  typedef struct packed {
    logic used;
    logic is_reg;
    logic [2:0] rnum;
    logic [15:0] addr;
  } opnd_t;
endpackage

// ===== operand_address_generator.sv
module operand_address_generator
  import oag_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Control
  input wire logic start,
  output logic busy,
  output logic done,
  // Register preload, taken while idle
  input wire logic load_en,
  input wire logic [2:0] load_idx,
  input wire logic [15:0] load_data,
  output logic [15:0] pc,
  // Memory read port
  output logic mem_req,
  output logic [15:0] mem_addr,
  input wire logic mem_ack,
  input wire logic [15:0] mem_rdata,
  // Results
  output logic [15:0] instr,
  output decode_t dec_o,
  output opnd_t src_o,
  output opnd_t dst_o
);

  // Classify an instruction word
  function automatic decode_t decode_word(input logic [15:0] w);
    decode_t d;
    d = '{fmt: FMT_NONE, kind: other_op, byte_op: 1'b0};
    if (w[14:12] != 3'h0 && w[14:12] != 3'h7) begin
      d = '{fmt: FMT_DOUBLE, kind: dual_op,
            byte_op: w[BYTE_BIT] && (w[14:12] != 3'h6)};
    end else if (w[15:12] == 4'h7) begin
      d.fmt = FMT_REGSRC;
      case (w[11:9])
        3'h0: d.kind = product_op;
        3'h1: d.kind = quotient_op;
        3'h2: d.kind = arith_shift_op;
        3'h3: d.kind = arith_shift_pair_op;
        3'h4: begin
          d.fmt = FMT_SINGLE;
          d.kind = xor_op;
        end
        default: d.fmt = FMT_NONE;
      endcase
    end else if (w[14:12] == 3'h0) begin
      d.fmt = FMT_SINGLE;
      d.byte_op = w[BYTE_BIT];
      case (w[11:6])
        6'h01: d.kind = w[BYTE_BIT] ? other_op : jump_op;
        6'h03: d.kind = w[BYTE_BIT] ? other_op : byte_swap_op;
        6'h28: d.kind = clear_op;
        6'h29: d.kind = invert_op;
        6'h2A: d.kind = plus_one_op;
        6'h2B: d.kind = minus_one_op;
        6'h2C: d.kind = sign_flip_op;
        6'h2D: d.kind = carry_add_op;
        6'h2E: d.kind = carry_subtract_op;
        6'h2F: d.kind = probe_op;
        6'h30: d.kind = rotate_right_op;
        6'h31: d.kind = rotate_left_op;
        6'h32: d.kind = arith_shift_right_op;
        6'h33: d.kind = arith_shift_left_op;
        6'h34: d.kind = w[BYTE_BIT] ? status_byte_write_op : other_op;
        6'h37: d.kind = w[BYTE_BIT] ? status_byte_read_op : sign_extend_op;
        6'h3A: d.kind = w[BYTE_BIT] ? other_op : test_and_set_op;
        6'h3B: d.kind = w[BYTE_BIT] ? other_op : locked_write_op;
        default: d.kind = other_op;
      endcase
      // Unlisted codes carry no operand here
      if (d.kind == other_op) begin
        d = '{fmt: FMT_NONE, kind: other_op, byte_op: 1'b0};
      end
    end
    return d;
  endfunction

  // State and working registers
  state_t state_r, state_nxt;
  sel_t sel_r, sel_nxt;
  logic [15:0] ir_r, ir_nxt;
  logic [5:0] spec_r, spec_nxt;
  logic [15:0] maddr_r, maddr_nxt;
  decode_t dec_r, dec_nxt;
  opnd_t src_r, src_nxt, dst_r, dst_nxt;
  logic [15:0] regs_r [8];
  // Register file write request
  logic rf_we;
  logic [2:0] rf_idx;
  logic [15:0] rf_val;
  // Operand completion
  logic finish;
  opnd_t res;

  // Specifier fields: mode above register
  wire logic [2:0] cur_mode = spec_r[5:3];
  wire logic [2:0] cur_rn = spec_r[2:0];
  wire logic [15:0] cur_val = regs_r[cur_rn];
  // Stack pointer and counter always step by a word
  wire logic wide_step = (cur_rn == SP_IDX) || (cur_rn == PC_IDX);
  wire logic [15:0] step =
    (dec_r.byte_op && !wide_step) ? BYTE_STEP : WORD_STEP;
  wire logic [15:0] dec2 = cur_val - WORD_STEP;
  // Index sum uses counter as already stepped past the word
  wire logic [15:0] xsum = cur_val + mem_rdata;
  wire logic [15:0] pc_next = pc + WORD_STEP;

  // Sequencer and address arithmetic
  always_comb begin
    state_nxt = state_r;
    sel_nxt = sel_r;
    ir_nxt = ir_r;
    spec_nxt = spec_r;
    maddr_nxt = maddr_r;
    dec_nxt = dec_r;
    src_nxt = src_r;
    dst_nxt = dst_r;
    rf_we = 1'b0;
    rf_idx = cur_rn;
    rf_val = cur_val;
    finish = 1'b0;
    res = '{used: 1'b1, is_reg: 1'b0, rnum: cur_rn, addr: cur_val};
    unique case (state_r)
      // Preload or begin an instruction
      ST_IDLE: begin
        if (load_en) begin
          rf_we = 1'b1;
          rf_idx = load_idx;
          rf_val = load_data;
        end else if (start) begin
          maddr_nxt = pc;
          src_nxt = '0;
          dst_nxt = '0;
          state_nxt = ST_FETCH;
        end
      end
      // Opcode fetch through the counter
      ST_FETCH: begin
        if (mem_ack) begin
          ir_nxt = mem_rdata;
          rf_we = 1'b1;
          rf_idx = PC_IDX;
          rf_val = pc_next;
          state_nxt = ST_DECODE;
        end
      end
      // Pick the first specifier; source before destination
      ST_DECODE: begin
        dec_nxt = decode_word(ir_r);
        state_nxt = ST_SPEC;
        sel_nxt = SEL_DST;
        spec_nxt = ir_r[DST_LO +: 6];
        unique case (dec_nxt.fmt)
          FMT_NONE: state_nxt = ST_DONE;
          FMT_SINGLE: sel_nxt = SEL_DST;
          FMT_DOUBLE: begin
            sel_nxt = SEL_SRC;
            spec_nxt = ir_r[SRC_LO +: 6];
          end
          FMT_REGSRC: begin
            sel_nxt = SEL_SRC;
            dst_nxt = '{used: 1'b1, is_reg: 1'b1,
                        rnum: ir_r[REG_LO +: 3], addr: '0};
          end
        endcase
      end
      // Resolve one specifier
      ST_SPEC: begin
        unique case (cur_mode)
          MODE_REG: begin
            res.is_reg = 1'b1;
            res.addr = '0;
            finish = 1'b1;
          end
          MODE_DEF: finish = 1'b1;
          // Pop or immediate: address first, then step
          MODE_INC: begin
            rf_we = 1'b1;
            rf_val = cur_val + step;
            finish = 1'b1;
          end
          // Pointer at register; absolute when on the counter
          MODE_INCDEF: begin
            rf_we = 1'b1;
            rf_val = cur_val + WORD_STEP;
            maddr_nxt = cur_val;
            state_nxt = ST_INDIR;
          end
          // Push: step first, then address
          MODE_DECR: begin
            rf_we = 1'b1;
            rf_val = cur_val - step;
            res.addr = cur_val - step;
            finish = 1'b1;
          end
          MODE_DECDEF: begin
            rf_we = 1'b1;
            rf_val = dec2;
            maddr_nxt = dec2;
            state_nxt = ST_INDIR;
          end
          // Index word follows in the stream
          MODE_IDX, MODE_IDXDEF: begin
            rf_we = 1'b1;
            rf_idx = PC_IDX;
            rf_val = pc_next;
            maddr_nxt = pc;
            state_nxt = ST_XWORD;
          end
        endcase
      end
      // Index word arrived; base register left untouched
      ST_XWORD: begin
        if (mem_ack) begin
          if (cur_mode == MODE_IDX) begin
            res.addr = xsum;
            finish = 1'b1;
          end else begin
            maddr_nxt = xsum;
            state_nxt = ST_INDIR;
          end
        end
      end
      // Pointer word arrived
      ST_INDIR: begin
        if (mem_ack) begin
          res.addr = mem_rdata;
          finish = 1'b1;
        end
      end
      ST_DONE: state_nxt = ST_IDLE;
    endcase
    // Store operand, move on to destination if any
    if (finish) begin
      if (sel_r == SEL_SRC) begin
        src_nxt = res;
      end else begin
        dst_nxt = res;
      end
      if (sel_r == SEL_SRC && dec_r.fmt == FMT_DOUBLE) begin
        sel_nxt = SEL_DST;
        spec_nxt = ir_r[DST_LO +: 6];
        state_nxt = ST_SPEC;
      end else begin
        state_nxt = ST_DONE;
      end
    end
  end

  // Working registers
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state_r <= ST_IDLE;
      sel_r <= SEL_SRC;
      ir_r <= WORD_RESET;
      spec_r <= '0;
      maddr_r <= WORD_RESET;
      dec_r <= '{fmt: FMT_NONE, kind: other_op, byte_op: 1'b0};
      src_r <= '0;
      dst_r <= '0;
    end else begin
      state_r <= state_nxt;
      sel_r <= sel_nxt;
      ir_r <= ir_nxt;
      spec_r <= spec_nxt;
      maddr_r <= maddr_nxt;
      dec_r <= dec_nxt;
      src_r <= src_nxt;
      dst_r <= dst_nxt;
    end
  end

  // General register file
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      for (int i = 0; i < 8; i++) begin
        regs_r[i] <= REG_RESET;
      end
    end else if (rf_we) begin
      regs_r[rf_idx] <= rf_val;
    end
  end

  // Outputs
  assign pc = regs_r[PC_IDX];
  assign busy = (state_r != ST_IDLE);
  assign done = (state_r == ST_DONE);
  assign mem_req = (state_r == ST_FETCH) || (state_r == ST_XWORD) ||
                   (state_r == ST_INDIR);
  assign mem_addr = maddr_r;
  assign instr = ir_r;
  assign dec_o = dec_r;
  assign src_o = src_r;
  assign dst_o = dst_r;

  // Checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  wire logic in_spec = (state_r == ST_SPEC);

  property p_fetch_step;
    state_r == ST_FETCH && mem_ack |=> pc == $past(pc) + WORD_STEP;
  endproperty
  a_fetch_step: assert property (p_fetch_step)
    else $error("counter not stepped by two on fetch");

  property p_decdef;
    in_spec && cur_mode == MODE_DECDEF |=>
      state_r == ST_INDIR && mem_addr == $past(cur_val) - WORD_STEP &&
      regs_r[$past(cur_rn)] == mem_addr;
  endproperty
  a_decdef: assert property (p_decdef)
    else $error("autodecrement-deferred pointer wrong");

  property p_idxdef;
    state_r == ST_XWORD && mem_ack && cur_mode == MODE_IDXDEF |=>
      state_r == ST_INDIR && mem_addr == $past(cur_val + mem_rdata);
  endproperty
  a_idxdef: assert property (p_idxdef)
    else $error("index-deferred pointer address wrong");

  property p_sp_step;
    in_spec && cur_rn == SP_IDX &&
      (cur_mode == MODE_INC || cur_mode == MODE_DECR) |=>
      regs_r[SP_IDX][0] == $past(cur_val[0]) &&
      (regs_r[SP_IDX] - $past(cur_val) == WORD_STEP ||
       $past(cur_val) - regs_r[SP_IDX] == WORD_STEP);
  endproperty
  a_sp_step: assert property (p_sp_step)
    else $error("stack pointer step not two");

  property p_byte_inc;
    in_spec && cur_mode == MODE_INC && dec_r.byte_op &&
      cur_rn < SP_IDX |=> regs_r[$past(cur_rn)] == $past(cur_val) + BYTE_STEP;
  endproperty
  a_byte_inc: assert property (p_byte_inc)
    else $error("byte autoincrement step not one");

  property p_absolute;
    in_spec && cur_mode == MODE_INCDEF && cur_rn == PC_IDX |=>
      mem_addr == $past(pc) && pc == $past(pc) + WORD_STEP
      ##1 (state_r == ST_INDIR) [*1];
  endproperty
  a_absolute: assert property (p_absolute)
    else $error("absolute mode fetch wrong");

  // Base register is looked up by the number held while waiting
  property p_index_keep;
    state_r == ST_XWORD && cur_rn != PC_IDX |=>
      regs_r[$past(cur_rn)] == $past(cur_val);
  endproperty
  a_index_keep: assert property (p_index_keep)
    else $error("index base register modified");

  property p_byte_mark;
    state_r == ST_DECODE ##1 dec_r.byte_op |-> ir_r[BYTE_BIT];
  endproperty
  a_byte_mark: assert property (p_byte_mark)
    else $error("byte flag without bit 15");

  property p_regsrc;
    state_r == ST_DECODE && ir_r[15:12] == 4'h7 && ir_r[11:9] < 3'h4 |=>
      dst_r.is_reg && dst_r.rnum == ir_r[REG_LO +: 3] && sel_r == SEL_SRC;
  endproperty
  a_regsrc: assert property (p_regsrc)
    else $error("register-source format misdecoded");

  c_immediate: cover property (in_spec && cur_mode == MODE_INC &&
                               cur_rn == PC_IDX);
  c_rel_def: cover property (state_r == ST_XWORD && cur_rn == PC_IDX &&
                             cur_mode == MODE_IDXDEF ##[1:20] done);
  c_double: cover property (dec_r.fmt == FMT_DOUBLE && done &&
                            !src_r.is_reg && !dst_r.is_reg);
endmodule

// ===== test_operand_address_generator.sv
module test_operand_address_generator
  import oag_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  // Bench side signals
  logic clk, rst, start, busy, done, load_en, mem_req, mem_ack;
  logic [2:0] load_idx;
  logic [15:0] load_data, pc, mem_addr, mem_rdata, instr;
  decode_t dec_o;
  opnd_t src_o, dst_o;
  logic [3:0] delay;
  // Tallies
  int err_total, cmp_count;

  // Block under test
  operand_address_generator dut (.clk(clk), .rst(rst), .start(start),
    .busy(busy), .done(done), .load_en(load_en), .load_idx(load_idx),
    .load_data(load_data), .pc(pc), .mem_req(mem_req),
    .mem_addr(mem_addr), .mem_ack(mem_ack), .mem_rdata(mem_rdata),
    .instr(instr), .dec_o(dec_o), .src_o(src_o), .dst_o(dst_o));
  // Memory on the far side
  mem_model mem (.clk(clk), .rst(rst), .mem_req(mem_req),
    .mem_addr(mem_addr), .mem_ack(mem_ack), .mem_rdata(mem_rdata),
    .delay(delay));

  // 200 MHz clock
  always #2.5 clk = ~clk;

  // Expected operand, memory or register
  function automatic opnd_t op(logic r, logic [2:0] n, logic [15:0] a);
    return '{1'b1, r, n, a};
  endfunction

  // Compare and count
  task automatic check(string what, logic [31:0] got, logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      err_total++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask

  // Verdict and end of run
  task automatic results;
    $display("compares %0d mismatches %0d", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  // Place a word in memory
  task automatic put(logic [15:0] a, logic [15:0] w);
    mem.words[a[12:1]] = w;
  endtask

  // Preload one register while idle
  task automatic load(logic [2:0] idx, logic [15:0] val);
    @(posedge clk);
    load_en <= 1'b1;
    load_idx <= idx;
    load_data <= val;
    @(posedge clk);
    load_en <= 1'b0;
  endtask

  // Run one instruction from address at, bounded wait for done
  task automatic run(logic [15:0] at, logic [15:0] w0);
    int n;
    put(at, w0);
    load(3'h7, at);
    start <= 1'b1;
    @(posedge clk);
    start <= 1'b0;
    n = 0;
    do begin
      @(posedge clk);
      #1;
      n++;
    end while (done !== 1'b1 && n < 200);
    if (done !== 1'b1) begin
      check("done", done, 1'b1);
      results();
    end
  endtask

  // Absolute: word after opcode is the address
  task automatic t_absolute;
    put(16'h0102, 16'h0240);
    run(16'h0100, 16'h0A1F);
    check("dst", dst_o, op(1'b0, 3'h7, 16'h0240));
    check("pc", pc, 16'h0104);
    check("src", src_o.used, 1'b0);
    check("fmt", dec_o.fmt, FMT_SINGLE);
    check("instr", instr, 16'h0A1F);
    check("busy", busy, 1'b1);
    $display("absolute end");
  endtask

  // Immediate: operand sits at the counter
  task automatic t_immediate;
    put(16'h0202, 16'h0008);
    run(16'h0200, 16'h65C0);
    check("src", src_o, op(1'b0, 3'h7, 16'h0202));
    check("dst", dst_o, op(1'b1, 3'h0, 16'h0000));
    check("pc", pc, 16'h0204);
    $display("immediate end");
  endtask

  // Relative, word then byte: counter steps two each time
  task automatic t_relative;
    for (int b = 0; b < 2; b++) begin
      put(16'h0302, 16'h002C);
      run(16'h0300, {b[0], 15'h0AB7});
      check("dst", dst_o, op(1'b0, 3'h7, 16'h0330));
      check("pc", pc, 16'h0304);
      check("byte", dec_o.byte_op, b[0]);
    end
    $display("relative end");
  endtask

  // Relative-deferred against a slow memory
  task automatic t_reldef;
    delay <= 4'h3;
    put(16'h0402, 16'h0010);
    put(16'h0414, 16'h1234);
    run(16'h0400, 16'h0A3F);
    check("dst", dst_o, op(1'b0, 3'h7, 16'h1234));
    check("pc", pc, 16'h0404);
    delay <= 4'h0;
    $display("reldef end");
  endtask

  // Autodecrement-deferred, then look at the register
  task automatic t_decdef;
    load(3'h0, 16'h0100);
    put(16'h00FE, 16'h0ABC);
    run(16'h0500, 16'h0A68);
    check("dst", dst_o, op(1'b0, 3'h0, 16'h0ABC));
    run(16'h0510, 16'h0A08);
    check("r0", dst_o.addr, 16'h00FE);
    $display("decdef end");
  endtask

  // Index-deferred must leave the base register alone
  task automatic t_idxdef;
    load(3'h2, 16'h0010);
    put(16'h0602, 16'h0200);
    put(16'h0210, 16'h0555);
    run(16'h0600, 16'h6E81);
    check("src", src_o, op(1'b0, 3'h2, 16'h0555));
    check("dst", dst_o, op(1'b1, 3'h1, 16'h0000));
    run(16'h0610, 16'h0A0A);
    check("r2", dst_o.addr, 16'h0010);
    $display("idxdef end");
  endtask

  // Byte push and pop on the stack, byte step on r5
  task automatic t_stack;
    load(3'h6, 16'h0080);
    load(3'h5, 16'h0030);
    run(16'h0700, 16'h8A26);
    check("push", dst_o.addr, 16'h007E);
    run(16'h0710, 16'h8BD6);
    check("pop", dst_o.addr, 16'h007E);
    run(16'h0720, 16'h0A0E);
    check("sp", dst_o.addr, 16'h0080);
    run(16'h0730, 16'h8A15);
    run(16'h0740, 16'h0A0D);
    check("r5", dst_o.addr, 16'h0031);
    $display("stack end");
  endtask

  // Two extension words, both relative to the counter
  task automatic t_two;
    put(16'h0802, 16'h0010);
    put(16'h0804, 16'h0020);
    run(16'h0800, 16'h6DF7);
    check("src", src_o.addr, 16'h0814);
    check("dst", dst_o.addr, 16'h0826);
    check("pc", pc, 16'h0806);
    $display("two end");
  endtask

  // Register-source group with an immediate source
  task automatic t_regsrc;
    put(16'h0A02, 16'h0007);
    run(16'h0A00, 16'h70D7);
    check("src", src_o, op(1'b0, 3'h7, 16'h0A02));
    check("dst", dst_o, op(1'b1, 3'h3, 16'h0000));
    check("dec", dec_o, decode_t'{FMT_REGSRC, product_op, 1'b0});
    $display("regsrc end");
  endtask

  // Every listed opcode of both groups, register operands
  task automatic t_table;
    logic [15:0] code [24];
    op_kind_t kind [24];
    code = '{16'h0A00, 16'h0A40, 16'h0A80, 16'h0AC0, 16'h0B00, 16'h0B40,
      16'h0B80, 16'h0BC0, 16'h0C00, 16'h0C40, 16'h0C80, 16'h0CC0,
      16'h0040, 16'h00C0, 16'h8DC0, 16'h8D00, 16'h0DC0, 16'h0E80,
      16'h0EC0, 16'h7800, 16'h7000, 16'h7200, 16'h7400, 16'h7600};
    kind = '{clear_op, invert_op, plus_one_op, minus_one_op, sign_flip_op,
      carry_add_op, carry_subtract_op, probe_op, rotate_right_op,
      rotate_left_op, arith_shift_right_op, arith_shift_left_op, jump_op,
      byte_swap_op, status_byte_read_op, status_byte_write_op,
      sign_extend_op, test_and_set_op, locked_write_op, xor_op,
      product_op, quotient_op, arith_shift_op, arith_shift_pair_op};
    for (int i = 0; i < 24; i++) begin
      run(16'h0B00, code[i]);
      check("kind", dec_o.kind, kind[i]);
      check("fmt", dec_o.fmt, i < 20 ? FMT_SINGLE : FMT_REGSRC);
      check("opnd", dst_o, op(1'b1, 3'h0, 16'h0000));
    end
    $display("table end");
  endtask

  // Pointer through r3, then index off r4; bases checked after
  task automatic t_index;
    load(3'h3, 16'h0040);
    load(3'h4, 16'h0100);
    put(16'h0040, 16'h0777);
    put(16'h0C02, 16'h0200);
    run(16'h0C00, 16'h16F4);
    check("src", src_o, op(1'b0, 3'h3, 16'h0777));
    check("dst", dst_o, op(1'b0, 3'h4, 16'h0300));
    check("pc", pc, 16'h0C04);
    run(16'h0C10, 16'h0A0B);
    check("r3", dst_o.addr, 16'h0042);
    run(16'h0C20, 16'h0A0C);
    check("r4", dst_o.addr, 16'h0100);
    $display("index end");
  endtask

  // Reset, then the scenarios
  initial begin
    clk = 1'b0;
    rst = 1'b1;
    start = 1'b0;
    load_en = 1'b0;
    load_idx = 3'h0;
    load_data = 16'h0000;
    delay = 4'h0;
    err_total = 0;
    cmp_count = 0;
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    t_absolute();
    t_immediate();
    t_relative();
    t_reldef();
    t_decdef();
    t_idxdef();
    t_stack();
    t_two();
    t_regsrc();
    t_table();
    t_index();
    results();
  end
endmodule
